// ===== rtl/csd_regs.svh
`ifndef CSD_REGS_SVH
`define CSD_REGS_SVH

// Opcode bytes
`define CSD_OP_ASCII_ADJ_SUB   8'h3f
`define CSD_OP_DEC_ADJ_SUB     8'h2f
`define CSD_OP_GRP3_HI7        7'h7b
`define CSD_OP_SIGNED_MULTIPLY_IMM_MASK   8'hfd
`define CSD_OP_SIGNED_MULTIPLY_IMM        8'h69
`define CSD_OP_AAM             8'hd4
`define CSD_OP_AAD             8'hd5
`define CSD_OP_AA_SECOND       8'h0a
`define CSD_OP_BYTE_EXT        8'h98
`define CSD_OP_WORD_EXT        8'h99
`define CSD_OP_SHIFT1_HI7      7'h68
`define CSD_OP_SHIFTC_HI7      7'h69
`define CSD_OP_SHIFTI_HI7      7'h60
`define CSD_OP_TEST_RM_HI7     7'h42
`define CSD_OP_TEST_ACC_HI7    7'h54
`define CSD_OP_SMOVE_HI7       7'h52
`define CSD_OP_SCMP_HI7        7'h53
`define CSD_OP_SSCAN_HI7       7'h57
`define CSD_OP_SLOAD_HI7       7'h56
`define CSD_OP_SSTORE_HI7      7'h55
`define CSD_OP_SIN_HI7         7'h36
`define CSD_OP_SOUT_HI7        7'h37
`define CSD_OP_REP             8'hf3
`define CSD_OP_REPC_HI7        7'h79
`define CSD_OP_CALL_FAR        8'h9a
`define CSD_OP_RETF_IMM        8'hca
`define CSD_OP_JCC_HI4         4'h7
`define CSD_OP_LOOP            8'he2
`define CSD_OP_LOOPZ           8'he1
`define CSD_OP_JUMP_COUNT_ZERO            8'he3
`define CSD_OP_ENTER           8'hc8
`define CSD_OP_FRAME_A           8'hc9
`define CSD_OP_INT_TYPE        8'hcd
`define CSD_OP_INT3            8'hcc
`define CSD_OP_INTO            8'hce

// Group-3 and shift reg fields
`define CSD_REG_TEST           3'h0
`define CSD_REG_NOT            3'h2
`define CSD_REG_MUL            3'h4
`define CSD_REG_SIGNED_MULTIPLY           3'h5
`define CSD_REG_DIV            3'h6
`define CSD_REG_SIGNED_DIVIDE           3'h7
`define CSD_TTT_ILLEGAL        3'h6
`define CSD_MOD_REG            2'h3

// Clock counts
`define CSD_CLK_ADJ_SUB        12'd3
`define CSD_CLK_MUL_RB         12'd13
`define CSD_CLK_MUL_RW         12'd21
`define CSD_CLK_MUL_MB         12'd16
`define CSD_CLK_MUL_MW         12'd24
`define CSD_CLK_SIGNED_MULTIPLY_IMM_R     12'd21
`define CSD_CLK_SIGNED_MULTIPLY_IMM_M     12'd24
`define CSD_CLK_DIV_RB         12'd14
`define CSD_CLK_DIV_RW         12'd22
`define CSD_CLK_DIV_MB         12'd17
`define CSD_CLK_DIV_MW         12'd25
`define CSD_CLK_SIGNED_DIVIDE_RB        12'd17
`define CSD_CLK_SIGNED_DIVIDE_RW        12'd25
`define CSD_CLK_SIGNED_DIVIDE_MB        12'd20
`define CSD_CLK_SIGNED_DIVIDE_MW        12'd28
`define CSD_CLK_AAM            12'd16
`define CSD_CLK_AAD            12'd14
`define CSD_CLK_EXTEND         12'd2
`define CSD_CLK_SH1_R          12'd2
`define CSD_CLK_SH1_M          12'd7
`define CSD_CLK_SHN_R          12'd5
`define CSD_CLK_SHN_M          12'd8
`define CSD_CLK_TEST_RR        12'd2
`define CSD_CLK_TEST_M         12'd6
`define CSD_CLK_TEST_IR        12'd3
`define CSD_CLK_NOT_R          12'd2
`define CSD_CLK_NOT_M          12'd7
`define CSD_CLK_SMOVE          12'd5
`define CSD_CLK_SCMP           12'd8
`define CSD_CLK_SSCAN          12'd7
`define CSD_CLK_SLOAD          12'd5
`define CSD_CLK_SSTORE         12'd3
`define CSD_CLK_SPORT          12'd5
`define CSD_CLK_REP_BASE       12'd5
`define CSD_CLK_REP_STORE_BASE 12'd4
`define CSD_MUL_REP_MOVE       12'd4
`define CSD_MUL_REP_STORE      12'd3
`define CSD_MUL_REP_CMP        12'd9
`define CSD_MUL_REP_SCAN       12'd8
`define CSD_CLK_GATE_SAME      12'd41
`define CSD_CLK_GATE_DIFF      12'd82
`define CSD_CLK_GATE_PARM      12'd86
`define CSD_MUL_GATE_PARM      12'd4
`define CSD_CLK_RETF_IMM       12'd15
`define CSD_CLK_JCC_TAKEN      12'd7
`define CSD_CLK_JCC_NOT        12'd3
`define CSD_CLK_LOOP_TAKEN     12'd8
`define CSD_CLK_LOOP_NOT       12'd4
`define CSD_CLK_ENTER_L0       12'd11
`define CSD_CLK_ENTER_L1       12'd15
`define CSD_CLK_ENTER_LN       12'd16
`define CSD_MUL_ENTER          12'd4
`define CSD_CLK_FRAME_A          12'd5
`define CSD_CLK_INTO_TAKEN     12'd24
`define CSD_CLK_INTO_NOT       12'd3
`define CSD_CLK_INT            12'd23
`define CSD_CLK_EA3_EXTRA      12'd1

`endif

// ===== rtl/csd_pkg.sv
package csd_pkg;
	typedef enum logic [5:0] {
		CSD_CLS_NONE, CSD_CLS_ADJ_SUB, CSD_CLS_MUL, CSD_CLS_SIGNED_MULTIPLY, CSD_CLS_SIGNED_MULTIPLY_IMM,
		CSD_CLS_DIV, CSD_CLS_SIGNED_DIVIDE, CSD_CLS_AAM, CSD_CLS_AAD, CSD_CLS_EXTEND,
		CSD_CLS_SHIFT1, CSD_CLS_SHIFTN, CSD_CLS_TEST_RM, CSD_CLS_TEST_IMM_RM, CSD_CLS_TEST_ACC,
		CSD_CLS_NOT, CSD_CLS_SMOVE, CSD_CLS_SCMP, CSD_CLS_SSCAN, CSD_CLS_SLOAD,
		CSD_CLS_SSTORE, CSD_CLS_SPORT, CSD_CLS_CALL_GATE, CSD_CLS_RETF_IMM, CSD_CLS_JCC,
		CSD_CLS_LOOP, CSD_CLS_ENTER, CSD_CLS_FRAME_A, CSD_CLS_INT, CSD_CLS_INTO
	} csd_class_t;

	typedef enum logic [1:0] {
		CSD_GATE_SAME, CSD_GATE_DIFF, CSD_GATE_PARM
	} csd_gate_t;

	// Instruction bytes as presented by the fetch stream
	typedef struct packed {
		logic [7:0] prefix;
		logic       prefix_valid;
		logic [7:0] opcode;
		logic [7:0] modrm;
		logic [7:0] second;
	} csd_insn_t;

	// Execution context known only at run time
	typedef struct packed {
		logic       protected_mode;
		logic       ea_three;
		logic       branch_taken;
		logic       zero_flag;
		logic [1:0] gate_kind;
		logic [4:0] param_count;
		logic [4:0] nest_level;
		logic [15:0] count_register;
		logic [3:0] next_len;
	} csd_ctx_t;

	typedef struct packed {
		csd_class_t  cls;
		logic        word;
		logic        mem;
		logic [2:0]  shift_op_field;
		logic        rep;
		logic        rep_on_zero;
		logic        may_except;
		logic        no_result;
		logic        illegal;
		logic [15:0] clocks;
	} csd_dec_t;
endpackage

// ===== rtl/csd_modrm_split.sv
module csd_modrm_split (
	input  wire logic [7:0] modrm_in,
	output logic            mem_out,
	output logic [2:0]      reg_out
);
	assign mem_out = (modrm_in[7:6] != 2'h3);
	assign reg_out = modrm_in[5:3];
endmodule // csd_modrm_split

// ===== rtl/csd_rep_timer.sv
// Sums base + per * n, saturating; n comes from the count register
module csd_rep_timer #(
	parameter int CW = 16
) (
	input  wire logic [11:0]   base_in,
	input  wire logic [11:0]   per_in,
	input  wire logic [CW-1:0] n_in,
	output logic [15:0]        total_out
);
	logic [CW+12:0] full;
	if (CW < 1 || CW > 16) begin : g_bad_cw
		$error("csd_rep_timer: CW out of range");
	end
	assign full = (CW+13)'(base_in) + (CW+13)'(per_in) * (CW+13)'(n_in);
	assign total_out = (full > (CW+13)'(16'hffff)) ? 16'hffff : full[15:0];
endmodule // csd_rep_timer

// ===== rtl/csd_decoder.sv
`include "csd_regs.svh"
module csd_decoder (
	input  wire logic              clk_sys_in,
	input  wire logic              rst_n_in,
	input  wire logic              insn_valid_in,
	input  wire csd_pkg::csd_insn_t insn_in,
	input  wire csd_pkg::csd_ctx_t  ctx_in,
	output logic                   dec_valid_out,
	output csd_pkg::csd_dec_t      dec_out,
	output logic                   repeat_stop_out
);
	import csd_pkg::*;

	logic        mem;
	logic [2:0]  regf;
	logic [7:0]  op;
	logic        w;
	logic        rep_plain;
	logic        rep_cond;
	logic [11:0] rep_base;
	logic [11:0] rep_per;
	logic [15:0] rep_total;
	logic [11:0] m_len;
	logic [11:0] ea_extra;
	logic [11:0] sh_n;
	csd_dec_t    next_dec;

	csd_modrm_split u_split (
		.modrm_in (insn_in.modrm),
		.mem_out  (mem),
		.reg_out  (regf)
	);

	csd_rep_timer #(.CW(16)) u_rep (
		.base_in   (rep_base),
		.per_in    (rep_per),
		.n_in      (ctx_in.count_register),
		.total_out (rep_total)
	);

	assign op        = insn_in.opcode;
	assign w         = op[0];
	assign rep_plain = insn_in.prefix_valid && insn_in.prefix == `CSD_OP_REP;
	assign rep_cond  = insn_in.prefix_valid && insn_in.prefix[7:1] == `CSD_OP_REPC_HI7;
	assign m_len     = 12'(ctx_in.next_len);
	assign ea_extra  = (mem && ctx_in.ea_three) ? `CSD_CLK_EA3_EXTRA : 12'h000;
	// Shift count from the low byte of the count register; the decoder does not mask it further
	assign sh_n      = 12'(ctx_in.count_register[7:0]);

	// Repeat timing parameters picked ahead of the main decode
	always_comb begin
		rep_base = `CSD_CLK_REP_BASE;
		rep_per  = `CSD_MUL_REP_MOVE;
		unique case (1'b1)
			op[7:1] == `CSD_OP_SSTORE_HI7: begin
				rep_base = `CSD_CLK_REP_STORE_BASE;
				rep_per  = `CSD_MUL_REP_STORE;
			end
			op[7:1] == `CSD_OP_SCMP_HI7: begin
				rep_per = `CSD_MUL_REP_CMP;
			end
			op[7:1] == `CSD_OP_SSCAN_HI7: begin
				rep_per = `CSD_MUL_REP_SCAN;
			end
			default: begin
				rep_per = `CSD_MUL_REP_MOVE;
			end
		endcase
	end

	always_comb begin
		logic [15:0] c;
		logic        str;
		c = 16'h0000;
		str = 1'b0;
		next_dec = '0;
		next_dec.cls = CSD_CLS_NONE;
		next_dec.word = w;
		next_dec.mem = 1'b0;
		next_dec.shift_op_field = regf;
		if (op == `CSD_OP_ASCII_ADJ_SUB || op == `CSD_OP_DEC_ADJ_SUB) begin
			next_dec.cls = CSD_CLS_ADJ_SUB;
			next_dec.word = 1'b0;
			c = 16'(`CSD_CLK_ADJ_SUB);
		end else if (op[7:1] == `CSD_OP_GRP3_HI7) begin
			next_dec.mem = mem;
			unique case (regf)
				`CSD_REG_MUL: begin
					next_dec.cls = CSD_CLS_MUL;
					c = 16'(mem ? (w ? `CSD_CLK_MUL_MW : `CSD_CLK_MUL_MB)
						: (w ? `CSD_CLK_MUL_RW : `CSD_CLK_MUL_RB));
				end
				`CSD_REG_SIGNED_MULTIPLY: begin
					next_dec.cls = CSD_CLS_SIGNED_MULTIPLY;
					c = 16'(mem ? (w ? `CSD_CLK_MUL_MW : `CSD_CLK_MUL_MB)
						: (w ? `CSD_CLK_MUL_RW : `CSD_CLK_MUL_RB));
				end
				`CSD_REG_DIV: begin
					next_dec.cls = CSD_CLS_DIV;
					next_dec.may_except = 1'b1;
					c = 16'(mem ? (w ? `CSD_CLK_DIV_MW : `CSD_CLK_DIV_MB)
						: (w ? `CSD_CLK_DIV_RW : `CSD_CLK_DIV_RB));
				end
				`CSD_REG_SIGNED_DIVIDE: begin
					next_dec.cls = CSD_CLS_SIGNED_DIVIDE;
					next_dec.may_except = 1'b1;
					c = 16'(mem ? (w ? `CSD_CLK_SIGNED_DIVIDE_MW : `CSD_CLK_SIGNED_DIVIDE_MB)
						: (w ? `CSD_CLK_SIGNED_DIVIDE_RW : `CSD_CLK_SIGNED_DIVIDE_RB));
				end
				`CSD_REG_NOT: begin
					next_dec.cls = CSD_CLS_NOT;
					c = 16'(mem ? `CSD_CLK_NOT_M : `CSD_CLK_NOT_R);
				end
				`CSD_REG_TEST: begin
					next_dec.cls = CSD_CLS_TEST_IMM_RM;
					next_dec.no_result = 1'b1;
					c = 16'(mem ? `CSD_CLK_TEST_M : `CSD_CLK_TEST_IR);
				end
				default: begin
					next_dec.illegal = 1'b1;
				end
			endcase
			if (mem) begin
				c = c + 16'(ea_extra);
			end
		end else if ((op & `CSD_OP_SIGNED_MULTIPLY_IMM_MASK) == `CSD_OP_SIGNED_MULTIPLY_IMM) begin
			// Bit 1 is s: sign-extended byte immediate versus word immediate
			next_dec.cls = CSD_CLS_SIGNED_MULTIPLY_IMM;
			next_dec.word = 1'b1;
			next_dec.mem = mem;
			c = 16'(mem ? `CSD_CLK_SIGNED_MULTIPLY_IMM_M + ea_extra : `CSD_CLK_SIGNED_MULTIPLY_IMM_R);
		end else if ((op == `CSD_OP_AAM || op == `CSD_OP_AAD) && insn_in.second == `CSD_OP_AA_SECOND) begin
			next_dec.cls = (op == `CSD_OP_AAM) ? CSD_CLS_AAM : CSD_CLS_AAD;
			next_dec.word = 1'b0;
			next_dec.may_except = (op == `CSD_OP_AAM);
			c = 16'((op == `CSD_OP_AAM) ? `CSD_CLK_AAM : `CSD_CLK_AAD);
		end else if (op == `CSD_OP_BYTE_EXT || op == `CSD_OP_WORD_EXT) begin
			next_dec.cls = CSD_CLS_EXTEND;
			c = 16'(`CSD_CLK_EXTEND);
		end else if (op[7:1] == `CSD_OP_SHIFT1_HI7) begin
			next_dec.cls = CSD_CLS_SHIFT1;
			next_dec.mem = mem;
			next_dec.illegal = (regf == `CSD_TTT_ILLEGAL);
			c = 16'(mem ? `CSD_CLK_SH1_M + ea_extra : `CSD_CLK_SH1_R);
		end else if (op[7:1] == `CSD_OP_SHIFTC_HI7 || op[7:1] == `CSD_OP_SHIFTI_HI7) begin
			next_dec.cls = CSD_CLS_SHIFTN;
			next_dec.mem = mem;
			next_dec.illegal = (regf == `CSD_TTT_ILLEGAL);
			// Immediate form takes n from the byte after ModRM
			c = 16'((mem ? `CSD_CLK_SHN_M + ea_extra : `CSD_CLK_SHN_R)
				+ ((op[7:1] == `CSD_OP_SHIFTI_HI7) ? 12'(insn_in.second) : sh_n));
		end else if (op[7:1] == `CSD_OP_TEST_RM_HI7) begin
			next_dec.cls = CSD_CLS_TEST_RM;
			next_dec.mem = mem;
			next_dec.no_result = 1'b1;
			c = 16'(mem ? `CSD_CLK_TEST_M + ea_extra : `CSD_CLK_TEST_RR);
		end else if (op[7:1] == `CSD_OP_TEST_ACC_HI7) begin
			next_dec.cls = CSD_CLS_TEST_ACC;
			next_dec.no_result = 1'b1;
			c = 16'(`CSD_CLK_TEST_IR);
		end else if (op[7:1] == `CSD_OP_SMOVE_HI7) begin
			next_dec.cls = CSD_CLS_SMOVE;
			str = 1'b1;
			c = 16'(`CSD_CLK_SMOVE);
		end else if (op[7:1] == `CSD_OP_SCMP_HI7) begin
			next_dec.cls = CSD_CLS_SCMP;
			str = 1'b1;
			c = 16'(`CSD_CLK_SCMP);
		end else if (op[7:1] == `CSD_OP_SSCAN_HI7) begin
			next_dec.cls = CSD_CLS_SSCAN;
			str = 1'b1;
			c = 16'(`CSD_CLK_SSCAN);
		end else if (op[7:1] == `CSD_OP_SLOAD_HI7) begin
			next_dec.cls = CSD_CLS_SLOAD;
			str = 1'b1;
			c = 16'(`CSD_CLK_SLOAD);
		end else if (op[7:1] == `CSD_OP_SSTORE_HI7) begin
			next_dec.cls = CSD_CLS_SSTORE;
			str = 1'b1;
			c = 16'(`CSD_CLK_SSTORE);
		end else if (op[7:1] == `CSD_OP_SIN_HI7 || op[7:1] == `CSD_OP_SOUT_HI7) begin
			next_dec.cls = CSD_CLS_SPORT;
			str = 1'b1;
			c = 16'(`CSD_CLK_SPORT);
		end else if (op == `CSD_OP_CALL_FAR && ctx_in.protected_mode) begin
			next_dec.cls = CSD_CLS_CALL_GATE;
			unique case (csd_gate_t'(ctx_in.gate_kind))
				CSD_GATE_SAME: c = 16'(`CSD_CLK_GATE_SAME + m_len);
				CSD_GATE_DIFF: c = 16'(`CSD_CLK_GATE_DIFF + m_len);
				CSD_GATE_PARM: c = 16'(`CSD_CLK_GATE_PARM + `CSD_MUL_GATE_PARM * 12'(ctx_in.param_count)
					+ m_len);
				default: next_dec.illegal = 1'b1;
			endcase
		end else if (op == `CSD_OP_RETF_IMM && !ctx_in.protected_mode) begin
			// Protected-mode count is not given for this form
			next_dec.cls = CSD_CLS_RETF_IMM;
			c = 16'(`CSD_CLK_RETF_IMM + m_len);
		end else if (op[7:4] == `CSD_OP_JCC_HI4) begin
			next_dec.cls = CSD_CLS_JCC;
			next_dec.word = 1'b0;
			c = 16'(ctx_in.branch_taken ? `CSD_CLK_JCC_TAKEN + m_len : `CSD_CLK_JCC_NOT);
		end else if (op == `CSD_OP_LOOP || op == `CSD_OP_LOOPZ || op == `CSD_OP_JUMP_COUNT_ZERO) begin
			next_dec.cls = CSD_CLS_LOOP;
			next_dec.word = 1'b0;
			c = 16'(ctx_in.branch_taken ? `CSD_CLK_LOOP_TAKEN + m_len : `CSD_CLK_LOOP_NOT);
		end else if (op == `CSD_OP_ENTER) begin
			next_dec.cls = CSD_CLS_ENTER;
			next_dec.word = 1'b1;
			if (ctx_in.nest_level == 5'h00) begin
				c = 16'(`CSD_CLK_ENTER_L0);
			end else if (ctx_in.nest_level == 5'h01) begin
				c = 16'(`CSD_CLK_ENTER_L1);
			end else begin
				c = 16'(`CSD_CLK_ENTER_LN + `CSD_MUL_ENTER * 12'(ctx_in.nest_level - 5'h01));
			end
		end else if (op == `CSD_OP_FRAME_A) begin
			next_dec.cls = CSD_CLS_FRAME_A;
			next_dec.word = 1'b1;
			c = 16'(`CSD_CLK_FRAME_A);
		end else if ((op == `CSD_OP_INT_TYPE || op == `CSD_OP_INT3) && !ctx_in.protected_mode) begin
			next_dec.cls = CSD_CLS_INT;
			c = 16'(`CSD_CLK_INT + m_len);
		end else if (op == `CSD_OP_INTO) begin
			next_dec.cls = CSD_CLS_INTO;
			next_dec.may_except = 1'b1;
			c = 16'(ctx_in.branch_taken ? `CSD_CLK_INTO_TAKEN + m_len : `CSD_CLK_INTO_NOT);
		end else begin
			next_dec.illegal = 1'b1;
		end
		if (str && (rep_plain || rep_cond)) begin
			next_dec.rep = 1'b1;
			next_dec.rep_on_zero = rep_cond && insn_in.prefix[0];
			c = rep_total;
		end
		next_dec.clocks = c;
	end

	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			dec_valid_out <= 1'b0;
		end else begin
			dec_valid_out <= insn_valid_in;
		end
	end

	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			dec_out <= '0;
		end else if (insn_valid_in) begin
			dec_out <= next_dec;
		end
	end

	// Stop compare/scan repetition when the flag disagrees with z
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			repeat_stop_out <= 1'b0;
		end else if (insn_valid_in) begin
			repeat_stop_out <= rep_cond && (next_dec.cls == CSD_CLS_SCMP || next_dec.cls == CSD_CLS_SSCAN)
				&& (ctx_in.zero_flag != insn_in.prefix[0]);
		end
	end
endmodule // csd_decoder

// ===== testbench/csd_decoder_properties.sv
module csd_decoder_properties (
	input wire logic               clk_sys_in,
	input wire logic               rst_n_in,
	input wire logic               insn_valid_in,
	input wire csd_pkg::csd_insn_t insn_in,
	input wire csd_pkg::csd_ctx_t  ctx_in,
	input wire logic               dec_valid_out,
	input wire csd_pkg::csd_dec_t  dec_out,
	input wire logic               repeat_stop_out
);
	import csd_pkg::*;
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (!rst_n_in);

	sequence took(logic [7:0] op);
		insn_valid_in && !insn_in.prefix_valid && insn_in.opcode == op;
	endsequence
	sequence ans(logic [15:0] n);
		dec_valid_out && dec_out.clocks == n;
	endsequence

	adj_sub_a: assert property (took(8'h3f) or took(8'h2f) |=> ans(16'd3))
		else $error("subtract adjust count wrong");
	extend_a: assert property (took(8'h98) or took(8'h99) |=> ans(16'd2))
		else $error("sign extend count wrong");
	ascii_mult_a: assert property (took(8'hd4) ##0 insn_in.second == 8'h0a |=> ans(16'd16))
		else $error("multiply adjust count wrong");
	div_reg_a: assert property (took(8'hf7) ##0 insn_in.modrm[7:3] == 5'h1e |=> ans(16'd22) ##0 dec_out.may_except)
		else $error("word divide decode wrong");
	word_bit_a: assert property (insn_valid_in && insn_in.opcode[7:1] == 7'h7b && insn_in.modrm[5:4] == 2'h2
		|=> dec_out.word == $past(insn_in.opcode[0]))
		else $error("operand size bit not followed");
	jcc_time_a: assert property (insn_valid_in && !insn_in.prefix_valid && insn_in.opcode[7:4] == 4'h7
		|=> ans($past(ctx_in.branch_taken) ? 16'd7 + $past(ctx_in.next_len) : 16'd3))
		else $error("conditional jump count wrong");
	loop_time_a: assert property (took(8'he2) or took(8'he1) or took(8'he3)
		|=> ans($past(ctx_in.branch_taken) ? 16'd8 + $past(ctx_in.next_len) : 16'd4))
		else $error("loop count wrong");
	enter_time_a: assert property (took(8'hc8) |=> ans($past(ctx_in.nest_level) == 5'h0 ? 16'd11 :
		$past(ctx_in.nest_level) == 5'h1 ? 16'd15 : 16'd12 + 16'd4 * $past(ctx_in.nest_level)))
		else $error("enter count wrong");
	rep_stop_a: assert property (insn_valid_in && insn_in.prefix_valid && insn_in.prefix[7:1] == 7'h79 &&
		(insn_in.opcode[7:1] == 7'h53 || insn_in.opcode[7:1] == 7'h57)
		|=> repeat_stop_out == ($past(ctx_in.zero_flag) != $past(insn_in.prefix[0])))
		else $error("repeat stop wrong");
	test_flags_a: assert property (took(8'h84) or took(8'h85) |=> dec_valid_out ##0 dec_out.no_result)
		else $error("test stores a result");
endmodule // csd_decoder_properties

bind csd_decoder csd_decoder_properties i_csd_decoder_properties (
	.clk_sys_in     (clk_sys_in),
	.rst_n_in       (rst_n_in),
	.insn_valid_in  (insn_valid_in),
	.insn_in        (insn_in),
	.ctx_in         (ctx_in),
	.dec_valid_out  (dec_valid_out),
	.dec_out        (dec_out),
	.repeat_stop_out(repeat_stop_out)
);

// ===== testbench/csd_fetch_model.sv
module csd_fetch_model (
	input  wire logic               clk_sys_in,
	input  wire logic               rst_n_in,
	input  wire logic               req_in,
	input  wire csd_pkg::csd_insn_t insn_req_in,
	input  wire csd_pkg::csd_ctx_t  ctx_req_in,
	output logic                    insn_valid_out,
	output csd_pkg::csd_insn_t      insn_out,
	output csd_pkg::csd_ctx_t       ctx_out
);
	timeunit 1ns;
	timeprecision 1ps;
	import csd_pkg::*;
	// Idle bytes toggle so a decoder that samples without valid shows up
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			insn_valid_out <= 1'b0;
			insn_out       <= '0;
			ctx_out        <= '0;
		end else if (req_in) begin
			insn_valid_out <= 1'b1;
			insn_out       <= insn_req_in;
			ctx_out        <= ctx_req_in;
		end else begin
			insn_valid_out <= 1'b0;
			insn_out       <= ~insn_out;
			ctx_out        <= ~ctx_out;
		end
	end
endmodule // csd_fetch_model

// ===== testbench/tb_cpu16_arith_string_branch_decoder.sv
module tb_cpu16_arith_string_branch_decoder;
	timeunit 1ns;
	timeprecision 1ps;
	import csd_pkg::*;
	logic      clk_sys_in = 1'b0;
	logic      rst_n_in   = 1'b0;
	logic      req        = 1'b0;
	csd_insn_t ri         = '0;
	csd_ctx_t  cx         = '0;
	logic      iv;
	csd_insn_t ii;
	csd_ctx_t  ic;
	logic      dv;
	csd_dec_t  d;
	logic      rs;
	int        error_cnt   = 0;
	int        check_count = 0;

	always #5 clk_sys_in = ~clk_sys_in;

	csd_fetch_model i_csd_fetch_model (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .req_in(req),
		.insn_req_in(ri), .ctx_req_in(cx), .insn_valid_out(iv), .insn_out(ii), .ctx_out(ic));
	csd_decoder i_csd_decoder (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .insn_valid_in(iv),
		.insn_in(ii), .ctx_in(ic), .dec_valid_out(dv), .dec_out(d), .repeat_stop_out(rs));

	task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("Error %s expected %0h seen %0h", nm, exp, seen);
		end
	endtask

	// Prefix 00 means no prefix byte
	task automatic op(logic [7:0] pre, logic [7:0] opc, logic [7:0] md, logic [7:0] sec, logic [15:0] exp);
		int i;
		@(posedge clk_sys_in);
		req <= 1'b1;
		ri  <= '{pre, pre != 8'h00, opc, md, sec};
		@(posedge clk_sys_in);
		req <= 1'b0;
		for (i = 0; i < 4 && dv !== 1'b1; i++) begin
			@(posedge clk_sys_in);
			#1;
		end
		check("valid", dv, 1);
		check("clocks", d.clocks, exp);
	endtask

	task automatic t_arith;
		int k;
		for (k = 0; k < 2; k++) begin
			cx = '0;
			cx.protected_mode = k[0];
			op(0, 8'h3f, 0, 0, 3);
			op(0, 8'h2f, 0, 0, 3);
		end
		op(0, 8'hd4, 0, 8'h0a, 16);
		op(0, 8'hd5, 0, 8'h0a, 14);
		op(0, 8'h98, 0, 0, 2);
		op(0, 8'h99, 0, 0, 2);
		op(0, 8'h69, 8'hc0, 0, 21);
		op(0, 8'h6b, 8'h01, 0, 24);
		$display("test arith done");
	endtask

	task automatic t_muldiv;
		logic [15:0] rb[4] = '{13, 13, 14, 17};
		logic [15:0] rw[4] = '{21, 21, 22, 25};
		logic [15:0] mb[4] = '{16, 16, 17, 20};
		logic [15:0] mw[4] = '{24, 24, 25, 28};
		logic [2:0]  g;
		int          r;
		for (r = 0; r < 4; r++) begin
			g  = 3'(r + 4);
			cx = '0;
			op(0, 8'hf6, {2'h3, g, 3'h0}, 0, rb[r]);
			check("word", d.word, 0);
			op(0, 8'hf7, {2'h3, g, 3'h2}, 0, rw[r]);
			check("word", d.word, 1);
			op(0, 8'hf6, {2'h0, g, 3'h4}, 0, mb[r]);
			check("mem", d.mem, 1);
			cx.ea_three = 1'b1;
			op(0, 8'hf7, {2'h0, g, 3'h1}, 0, mw[r] + 16'd1);
			check("except", d.may_except, r >= 2);
		end
		$display("test muldiv done");
	endtask

	task automatic t_logic;
		logic [2:0] t;
		int         k;
		cx = '0;
		cx.count_register = 16'd9;
		for (k = 0; k < 8; k++) begin
			t = 3'(k);
			// Reserved field still carries the shift timing; only the illegal flag marks it
			op(0, 8'hd0, {2'h3, t, 3'h1}, 0, 2);
			check("illegal", d.illegal, k == 6);
			if (k != 6) begin
				check("op field", d.shift_op_field, t);
			end
			op(0, 8'hd1, {2'h0, t, 3'h1}, 0, 7);
			check("mem", d.mem, 1);
			op(0, 8'hd3, {2'h3, t, 3'h0}, 0, 14);
			op(0, 8'hc1, {2'h0, t, 3'h1}, 8'h03, 11);
		end
		op(0, 8'h84, 8'hc1, 0, 2);
		check("no result", d.no_result, 1);
		op(0, 8'h85, 8'h01, 0, 6);
		op(0, 8'ha9, 0, 0, 3);
		op(0, 8'hf6, 8'hc0, 0, 3);
		op(0, 8'hf7, 8'h01, 0, 6);
		op(0, 8'hf6, 8'hd0, 0, 2);
		op(0, 8'hf7, 8'h11, 0, 7);
		$display("test logic done");
	endtask

	task automatic t_string;
		cx = '0;
		op(0, 8'ha4, 0, 0, 5);
		op(0, 8'ha7, 0, 0, 8);
		op(0, 8'hae, 0, 0, 7);
		op(0, 8'h6c, 0, 0, 5);
		op(0, 8'h6f, 0, 0, 5);
		cx.count_register = 16'd10;
		op(8'hf3, 8'ha5, 0, 0, 45);
		check("rep", d.rep, 1);
		op(8'hf3, 8'had, 0, 0, 45);
		op(8'hf3, 8'h6d, 0, 0, 45);
		op(8'hf3, 8'h6e, 0, 0, 45);
		op(8'hf3, 8'hab, 0, 0, 34);
		cx.count_register = 16'd3;
		cx.zero_flag = 1'b1;
		op(8'hf2, 8'ha6, 0, 0, 32);
		check("class", d.cls, CSD_CLS_SCMP);
		check("on zero", d.rep_on_zero, 0);
		check("stop", rs, 1);
		op(8'hf3, 8'haf, 0, 0, 29);
		check("stop", rs, 0);
		$display("test string done");
	endtask

	task automatic t_ctrl;
		int k;
		cx = '0;
		cx.protected_mode = 1'b1;
		cx.next_len = 4'd2;
		cx.param_count = 5'd3;
		for (k = 0; k < 3; k++) begin
			cx.gate_kind = 2'(k);
			op(0, 8'h9a, 0, 0, k == 0 ? 43 : k == 1 ? 84 : 100);
		end
		cx = '0;
		cx.next_len = 4'd3;
		op(0, 8'hca, 0, 0, 18);
		for (k = 0; k < 16; k++) begin
			cx.branch_taken = k[0];
			op(0, {4'h7, 4'(k)}, 0, 0, k[0] ? 10 : 3);
		end
		for (k = 0; k < 6; k++) begin
			cx.branch_taken = k[0];
			op(0, k < 2 ? 8'he2 : k < 4 ? 8'he1 : 8'he3, 0, 0, k[0] ? 11 : 4);
		end
		for (k = 0; k < 4; k++) begin
			cx.nest_level = 5'(k);
			op(0, 8'hc8, 0, 0, k == 0 ? 11 : k == 1 ? 15 : 16 + 4 * (k - 1));
		end
		op(0, 8'hc9, 0, 0, 5);
		op(0, 8'hcd, 0, 0, 26);
		op(0, 8'hcc, 0, 0, 26);
		cx.branch_taken = 1'b1;
		op(0, 8'hce, 0, 0, 27);
		cx.branch_taken = 1'b0;
		op(0, 8'hce, 0, 0, 3);
		$display("test control done");
	endtask

	task automatic final_report;
		$display("checks %0d errors %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	initial begin
		repeat (2) @(posedge clk_sys_in);
		rst_n_in <= 1'b1;
		t_arith;
		t_muldiv;
		t_logic;
		t_string;
		t_ctrl;
		final_report;
	end

	// About 340 cycles are needed; allow about fifteen times that
	initial begin
		#50000;
		error_cnt++;
		final_report;
	end
endmodule // tb_cpu16_arith_string_branch_decoder
